//--- logic/sbd_pkg.sv
// Shared constants for the shared-line command/data bus ends
`default_nettype none
package sbd_pkg;
	// Bus geometry and field positions on the shared lines
	localparam int SBD_LINES      = 16;
	localparam int SBD_BE_MSB     = 15;
	localparam int SBD_BE_LSB     = 12;
	localparam int SBD_AHI_MSB    = 7;
	localparam int SBD_AHI_LSB    = 2;
	localparam int SBD_NARROW_MSB = 7;

	// Layout of the packed pin vector that the device synchronises
	localparam int SBD_PIN_W      = 22;
	localparam int SBD_P_STRAP    = 21;
	localparam int SBD_P_HW_RESET_N     = 20;
	localparam int SBD_P_CSN      = 19;
	localparam int SBD_P_CMD      = 18;
	localparam int SBD_P_WRN      = 17;
	localparam int SBD_P_RDN      = 16;

	// Values after reset
	// Reset pin image is low, so the device never looks out of reset too early
	localparam logic [SBD_PIN_W-1:0] SBD_PIN_IDLE = 22'h2B0000;
	localparam logic [7:0]  SBD_ADDR_RST  = 8'h00;
	localparam logic [3:0]  SBD_BE_RST    = 4'h0;
	localparam logic [15:0] SBD_DATA_RST  = 16'h0000;
	localparam logic        SBD_WIDE_RST  = 1'b1;

	// Timing: clock period and the hardware reset hold time
	localparam int SBD_CLK_NS      = 8;
	localparam int SBD_RST_HOLD_MS = 10;
	localparam int SBD_RST_HOLD_CYC =
		(SBD_RST_HOLD_MS * 1000000 + SBD_CLK_NS - 1) / SBD_CLK_NS;

	// Host strobe shape in clock cycles
	localparam logic [3:0] SBD_SETUP_CYC  = 4'h2;
	localparam logic [3:0] SBD_STROBE_CYC = 4'h8;
	localparam logic [3:0] SBD_RECOV_CYC  = 4'h6;

	// Host access states, Gray coded along the usual path
	typedef enum logic [1:0] {
		SBD_IDLE   = 2'b00,
		SBD_SETUP  = 2'b01,
		SBD_STROBE = 2'b11,
		SBD_RECOV  = 2'b10
	} sbd_state_t;
endpackage : sbd_pkg
`default_nettype wire

//--- logic/sbd_if.sv
// Pin-level carrier joining the host end and the device end
`default_nettype none
interface sbd_if;
	logic [15:0] host_line;
	logic        host_line_oe;
	logic [15:0] dev_line;
	logic        dev_line_oe;
	logic [15:0] shared_line;
	logic        cmd_sel;
	logic        chip_select_n;
	logic        wr_n;
	logic        rd_n;
	logic        hw_reset_n;
	logic        bus_width_strap;

	// Resolved bus level; lines are pulled down when nobody drives
	assign shared_line = host_line_oe ? host_line :
		(dev_line_oe ? dev_line : 16'h0000);

	modport host (
		output host_line, host_line_oe, cmd_sel, chip_select_n,
		output wr_n, rd_n, hw_reset_n, bus_width_strap,
		input  shared_line
	);
	modport dev (
		output dev_line, dev_line_oe,
		input  shared_line, cmd_sel, chip_select_n,
		input  wr_n, rd_n, hw_reset_n, bus_width_strap
	);
endinterface : sbd_if
`default_nettype wire

//--- logic/sbd_host.sv
// Host end: drives address, byte enables and data onto the shared lines
`default_nettype none
module sbd_host
	import sbd_pkg::*;
#(
	parameter int RST_HOLD_CYC = SBD_RST_HOLD_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       wide_i,
	input  wire logic       start_i,
	input  wire logic       is_addr_i,
	input  wire logic       write_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [3:0] be_i,
	input  wire logic [15:0] wdata_i,
	output logic            busy_o,
	output logic            done_o,
	output logic [15:0]     rdata_o,
	sbd_if.host             bus
);
	sbd_state_t  state_reg;
	logic [3:0]  cnt_reg;
	logic [20:0] rst_cnt_reg;
	logic        rst_done_reg;
	logic        is_addr_reg;
	logic        write_reg;
	logic [15:0] line_reg;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rst_cnt_reg  <= 21'h000000;
			rst_done_reg <= 1'b0;
		end else if (!rst_done_reg) begin
			rst_cnt_reg  <= rst_cnt_reg + 21'h000001;
			rst_done_reg <= (rst_cnt_reg == 21'(RST_HOLD_CYC - 1));
		end
	end

	// Strap and reset pins come straight from flops
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bus.hw_reset_n      <= 1'b0;
			bus.bus_width_strap <= SBD_WIDE_RST;
		end else begin
			bus.hw_reset_n      <= rst_done_reg;
			bus.bus_width_strap <= wide_i;
		end
	end

	// Access sequencer
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg   <= SBD_IDLE;
			cnt_reg     <= 4'h0;
			is_addr_reg <= 1'b0;
			write_reg   <= 1'b0;
			line_reg    <= SBD_DATA_RST;
		end else begin
			case (state_reg)
				SBD_IDLE: begin
					if (start_i && rst_done_reg) begin
						state_reg   <= SBD_SETUP;
						cnt_reg     <= SBD_SETUP_CYC;
						is_addr_reg <= is_addr_i;
						write_reg   <= write_i | is_addr_i;
						// address phase layout
						// Wide mode still puts A1..A0 on lines 1..0; the device drops them
						if (is_addr_i) begin
							line_reg <= wide_i ?
								{be_i, 4'h0, addr_i} :
								{8'h00, addr_i};
						end else begin
							line_reg <= wide_i ? wdata_i : {8'h00, wdata_i[7:0]};
						end
					end
				end
				SBD_SETUP: begin
					cnt_reg <= cnt_reg - 4'h1;
					if (cnt_reg == 4'h1) begin
						state_reg <= SBD_STROBE;
						cnt_reg   <= SBD_STROBE_CYC;
					end
				end
				SBD_STROBE: begin
					cnt_reg <= cnt_reg - 4'h1;
					if (cnt_reg == 4'h1) begin
						state_reg <= SBD_RECOV;
						cnt_reg   <= SBD_RECOV_CYC;
					end
				end
				SBD_RECOV: begin
					cnt_reg <= cnt_reg - 4'h1;
					if (cnt_reg == 4'h1) begin
						state_reg <= SBD_IDLE;
					end
				end
				default: begin
					state_reg <= SBD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bus.chip_select_n <= 1'b1;
			bus.cmd_sel       <= 1'b0;
			bus.wr_n          <= 1'b1;
			bus.rd_n          <= 1'b1;
			bus.host_line     <= SBD_DATA_RST;
			bus.host_line_oe  <= 1'b0;
		end else begin
			bus.chip_select_n <= !(state_reg == SBD_SETUP || state_reg == SBD_STROBE);
			bus.cmd_sel       <= is_addr_reg && state_reg != SBD_IDLE;
			bus.wr_n          <= !(state_reg == SBD_STROBE && write_reg);
			bus.rd_n          <= !(state_reg == SBD_STROBE && !write_reg);
			bus.host_line     <= line_reg;
			bus.host_line_oe  <= write_reg && state_reg != SBD_IDLE;
		end
	end

	// Read data is taken on the last strobe cycle, when the device has long settled
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o <= SBD_DATA_RST;
			done_o  <= 1'b0;
			busy_o  <= 1'b1;
		end else begin
			done_o <= (state_reg == SBD_RECOV && cnt_reg == 4'h1);
			busy_o <= !rst_done_reg || state_reg != SBD_IDLE || start_i;
			if (state_reg == SBD_STROBE && cnt_reg == 4'h1 && !write_reg) begin
				rdata_o <= bus.shared_line;
			end
		end
	end
endmodule : sbd_host
`default_nettype wire

//--- logic/sbd_dev.sv
// Device end: decodes shared lines into address, byte enables and data
`default_nettype none
// Operation
// - Command low: lines carry data bits
// - Wide address phase: lines 15..12 byte enables
// - Address phase ignores lines 11 to 8
// - Address phase: lines 7..2 address bits
// - Narrow uses lines 1,0; wide ignores
// - Narrow host holds lines 15..8 low
// - Reset pin held low ten milliseconds
// - Access only while chip select low
// - Width strap sampled during reset
module sbd_dev
	import sbd_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [15:0] rd_data_i,
	output logic             in_reset_o,
	output logic             wide_o,
	output logic [7:0]       addr_o,
	output logic [3:0]       be_o,
	output logic             wr_pulse_o,
	output logic [15:0]      wdata_o,
	output logic             rd_pulse_o,
	sbd_if.dev               bus
);
	logic [SBD_PIN_W-1:0] pin_raw;
	logic [SBD_PIN_W-1:0] sync1_reg;
	logic [SBD_PIN_W-1:0] sync2_reg;
	logic [SBD_PIN_W-1:0] sync3_reg;
	logic [SBD_PIN_W-1:0] filt_reg;
	logic                 wr_prev_reg;
	logic                 rd_prev_reg;
	logic                 dev_rst;
	logic                 sel;
	logic                 wr_fall;
	logic                 rd_fall;
	logic [15:0]          lines;

	// Settled value: a bit moves only when the second and third stage agree
	function automatic logic [SBD_PIN_W-1:0] sbd_settle(
		input logic [SBD_PIN_W-1:0] old_v,
		input logic [SBD_PIN_W-1:0] s2,
		input logic [SBD_PIN_W-1:0] s3
	);
		logic [SBD_PIN_W-1:0] agree;
		agree = ~(s2 ^ s3);
		return (s2 & agree) | (old_v & ~agree);
	endfunction : sbd_settle

	// Narrow mode keeps the upper lane at zero so stale upper bits never leak
	function automatic logic [15:0] sbd_lane_mask(
		input logic        wide,
		input logic [15:0] v
	);
		return wide ? v : {8'h00, v[SBD_NARROW_MSB:0]};
	endfunction : sbd_lane_mask

	// Falling strobe inside a selected access
	function automatic logic sbd_fall(
		input logic sel_v,
		input logic prev_v,
		input logic now_v
	);
		return sel_v & prev_v & ~now_v;
	endfunction : sbd_fall

	// All host pins in one vector so they share one latency
	assign pin_raw = {bus.bus_width_strap, bus.hw_reset_n, bus.chip_select_n,
		bus.cmd_sel, bus.wr_n, bus.rd_n, bus.shared_line};

	// Three-stage synchroniser; stage one feeds stage two only
	// Stages reset to the pin levels seen in reset, so no false edge follows
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sync1_reg <= SBD_PIN_IDLE;
			sync2_reg <= SBD_PIN_IDLE;
			sync3_reg <= SBD_PIN_IDLE;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// Filtered pin image used by all decode below
	// A one-cycle glitch never reaches the decode; the price is one cycle of lag
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			filt_reg <= SBD_PIN_IDLE;
		end else begin
			filt_reg <= sbd_settle(filt_reg, sync2_reg, sync3_reg);
		end
	end

	// Internal reset: local reset or the filtered hardware reset pin
	// The pin is filtered first, so a short glitch cannot reset the decode
	assign dev_rst = reset_i | ~filt_reg[SBD_P_HW_RESET_N];

	// relies on host hold
	// Mirrors the filtered pin, so it releases a few cycles after the pin rises
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			in_reset_o <= 1'b1;
		end else begin
			in_reset_o <= ~filt_reg[SBD_P_HW_RESET_N];
		end
	end

	// strap capture
	// The strap pin is reused for other duties later, so it is only looked at in reset
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wide_o <= SBD_WIDE_RST;
		end else if (dev_rst) begin
			wide_o <= filt_reg[SBD_P_STRAP];
		end
	end

	// chip select gating
	// Deselected or in reset, every strobe is ignored
	assign sel   = ~filt_reg[SBD_P_CSN] & ~dev_rst;
	assign lines = filt_reg[SBD_LINES-1:0];

	// Strobe history for edge detection on the filtered image
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_prev_reg <= 1'b1;
			rd_prev_reg <= 1'b1;
		end else begin
			wr_prev_reg <= filt_reg[SBD_P_WRN];
			rd_prev_reg <= filt_reg[SBD_P_RDN];
		end
	end

	// An access starts on the falling edge of its strobe
	assign wr_fall = sbd_fall(sel, wr_prev_reg, filt_reg[SBD_P_WRN]);
	assign rd_fall = sbd_fall(sel, rd_prev_reg, filt_reg[SBD_P_RDN]);

	// Address phase decode
	// hold address
	// Held across any number of data accesses, so bursts need one address phase
	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			addr_o <= SBD_ADDR_RST;
			be_o   <= SBD_BE_RST;
		end else if (wr_fall && filt_reg[SBD_P_CMD]) begin
			addr_o[SBD_AHI_MSB:SBD_AHI_LSB] <= lines[SBD_AHI_MSB:SBD_AHI_LSB];
			// lines 11..8 unused
			// Whatever the host leaves on lines 11 to 8 is never read here
			if (wide_o) begin
				be_o        <= lines[SBD_BE_MSB:SBD_BE_LSB];
				addr_o[1:0] <= 2'b00;
			end else begin
				addr_o[1:0] <= lines[1:0];
				// Narrow access touches the one byte that A1..A0 picks
				be_o        <= 4'(4'h1 << lines[1:0]);
			end
		end
	end

	// Data phase write
	// Only a data phase writes; an address phase leaves the data word alone
	// data bits
	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			wdata_o    <= SBD_DATA_RST;
			wr_pulse_o <= 1'b0;
		end else begin
			wr_pulse_o <= wr_fall & ~filt_reg[SBD_P_CMD];
			if (wr_fall && !filt_reg[SBD_P_CMD]) begin
				wdata_o <= sbd_lane_mask(wide_o, lines);
			end
		end
	end

	// Read request pulse tells the user which address is about to be read
	// The user has only the one cycle that the pulse is high to present read data
	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			rd_pulse_o <= 1'b0;
		end else begin
			rd_pulse_o <= rd_fall & ~filt_reg[SBD_P_CMD];
		end
	end

	// Read drive while the data read strobe stands
	// no drive deselected
	// Release lags the host strobe by the filter depth; host recovery covers it
	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			bus.dev_line_oe <= 1'b0;
			bus.dev_line    <= SBD_DATA_RST;
		end else begin
			bus.dev_line_oe <= sel & ~filt_reg[SBD_P_RDN] & ~filt_reg[SBD_P_CMD];
			// data on lines
			// Follows rd_data_i every cycle so a late change still reaches the host
			bus.dev_line    <= sbd_lane_mask(wide_o, rd_data_i);
		end
	end
endmodule : sbd_dev
`default_nettype wire

//--- bench/sbd_monitor.sv
// Pin-level checker beside the interface joining host and device ends
`default_nettype none
module sbd_monitor #(
	parameter int RST_HOLD_CYC = 20
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [15:0] host_line,
	input  wire logic        host_line_oe,
	input  wire logic        dev_line_oe,
	input  wire logic        cmd_sel,
	input  wire logic        chip_select_n,
	input  wire logic        wr_n,
	input  wire logic        rd_n,
	input  wire logic        hw_reset_n,
	input  wire logic        bus_width_strap
);
	timeunit 1ns;
	timeprecision 1ps;
	int low_cnt;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Low time of the reset pin; saturates so a long hold cannot wrap
	always_ff @(posedge clk_i) begin
		if (reset_i || hw_reset_n) begin
			low_cnt <= 0;
		end else if (low_cnt < 1000) begin
			low_cnt <= low_cnt + 1;
		end
	end
	a_reset_hold_long: assert property ($rose(hw_reset_n) |-> low_cnt >= RST_HOLD_CYC - 1)
		else $error("reset pin released early");
	a_write_needs_select: assert property (!wr_n |-> !chip_select_n)
		else $error("write strobe without select");
	a_read_needs_select: assert property (!rd_n |-> !chip_select_n)
		else $error("read strobe without select");
	a_narrow_upper_zero: assert property (host_line_oe && !bus_width_strap |-> host_line[15:8] == 8'h00)
		else $error("upper lines driven in narrow mode");
	a_single_line_driver: assert property (!(host_line_oe && dev_line_oe))
		else $error("both ends drive the lines");
	a_addr_phase_write: assert property (cmd_sel && !chip_select_n |-> rd_n)
		else $error("read during address phase");
	a_strobe_eight_cycles: assert property ($fell(wr_n) |-> !wr_n [*8] ##1 wr_n)
		else $error("write strobe length wrong");
	a_lines_held_strobe: assert property (!wr_n |-> $stable(host_line) && $stable(cmd_sel))
		else $error("lines moved during strobe");
	a_strap_held_run: assert property (hw_reset_n |-> $stable(bus_width_strap))
		else $error("strap moved outside reset");
	// Main traffic kinds
	c_wide_addr: cover property ($fell(wr_n) && cmd_sel && bus_width_strap);
	c_narrow_write: cover property ($fell(wr_n) && !bus_width_strap);
	c_read: cover property ($fell(rd_n));
endmodule : sbd_monitor
`default_nettype wire

//--- bench/sbd_tb_top.sv
// Self-checking bench joining host and device ends over the shared lines
`default_nettype none
module sbd_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i     = 1'b0;
	logic        reset_i   = 1'b1;
	logic        wide_i    = 1'b1;
	logic        start_i   = 1'b0;
	logic        is_addr_i = 1'b0;
	logic        write_i   = 1'b0;
	logic [7:0]  addr_i    = 8'h00;
	logic [3:0]  be_i      = 4'h0;
	logic [15:0] wdata_i   = 16'h0000;
	logic [15:0] rd_data_i = 16'h0000;
	logic        busy_o, done_o, in_reset_o, wide_o, wr_pulse_o, rd_pulse_o;
	logic [15:0] rdata_o, wdata_o;
	logic [7:0]  addr_o;
	logic [3:0]  be_o;
	int          n_fail = 0;
	int          num_checks = 0;
	int          seed = 4704;
	int          n_wr = 0;
	int          n_rd = 0;
	sbd_if bus_if ();
	// Free-running clock at 125 MHz
	always #4 clk_i = ~clk_i;
	// Device strobe pulses seen; each data access must give exactly one
	always @(posedge clk_i) begin
		if (wr_pulse_o === 1'b1) begin
			n_wr++;
		end
		if (rd_pulse_o === 1'b1) begin
			n_rd++;
		end
	end
	// Short reset hold keeps the run brief
	sbd_host #(.RST_HOLD_CYC(20)) sbd_host_i (.clk_i(clk_i), .reset_i(reset_i),
		.wide_i(wide_i), .start_i(start_i), .is_addr_i(is_addr_i), .write_i(write_i),
		.addr_i(addr_i), .be_i(be_i), .wdata_i(wdata_i), .busy_o(busy_o),
		.done_o(done_o), .rdata_o(rdata_o), .bus(bus_if));
	sbd_dev sbd_dev_i (.clk_i(clk_i), .reset_i(reset_i), .rd_data_i(rd_data_i),
		.in_reset_o(in_reset_o), .wide_o(wide_o), .addr_o(addr_o), .be_o(be_o),
		.wr_pulse_o(wr_pulse_o), .wdata_o(wdata_o), .rd_pulse_o(rd_pulse_o), .bus(bus_if));
	sbd_monitor #(.RST_HOLD_CYC(20)) sbd_monitor_i (.clk_i(clk_i), .reset_i(reset_i),
		.host_line(bus_if.host_line), .host_line_oe(bus_if.host_line_oe),
		.dev_line_oe(bus_if.dev_line_oe), .cmd_sel(bus_if.cmd_sel),
		.chip_select_n(bus_if.chip_select_n), .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n),
		.hw_reset_n(bus_if.hw_reset_n), .bus_width_strap(bus_if.bus_width_strap));
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Bounded wait until host is free and device out of reset
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while ((busy_o !== 1'b0 || in_reset_o !== 1'b0) && n < 500);
		chk({15'h0000, busy_o | in_reset_o}, 16'h0000);
	endtask : wait_idle
	// One host access; returns at the negedge where done is seen
	task automatic access(input logic a, input logic w, input logic [7:0] ad,
		input logic [3:0] b, input logic [15:0] d);
		int n;
		wait_idle();
		@(posedge clk_i);
		start_i   <= 1'b1;
		is_addr_i <= a;
		write_i   <= w;
		addr_i    <= ad;
		be_i      <= b;
		wdata_i   <= d;
		@(posedge clk_i);
		start_i <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (done_o !== 1'b1 && n < 100);
		chk({15'h0000, done_o}, 16'h0001);
	endtask : access
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize
	// Both bus widths, corner address first, then random traffic
	initial begin
		logic [7:0]  a, ea;
		logic [3:0]  b;
		logic [15:0] d, m;
		int          ew, er;
		ew = 0;
		er = 0;
		for (int w = 1; w >= 0; w--) begin
			@(posedge clk_i);
			reset_i <= 1'b1;
			wide_i  <= w[0];
			repeat (12) @(posedge clk_i);
			chk({15'h0000, in_reset_o}, 16'h0001);
			chk({15'h0000, busy_o}, 16'h0001);
			reset_i <= 1'b0;
			wait_idle();
			chk({15'h0000, wide_o}, {15'h0000, w[0]});
			m = w[0] ? 16'hFFFF : 16'h00FF;
			for (int i = 0; i < 12; i++) begin
				a  = (i == 0) ? 8'hFF : 8'($random(seed));
				b  = (i == 0) ? 4'hF : 4'($random(seed));
				d  = 16'($random(seed));
				ea = w[0] ? {a[7:2], 2'b00} : a;
				access(1'b1, 1'b1, a, b, d);
				chk({8'h00, addr_o}, {8'h00, ea});
				chk({12'h000, be_o}, {12'h000, w[0] ? b : 4'h1 << a[1:0]});
				chk(16'(n_wr), 16'(ew));
				access(1'b0, 1'b1, 8'h00, 4'h0, d);
				ew++;
				chk(16'(n_wr), 16'(ew));
				chk(wdata_o, d & m);
				chk({8'h00, addr_o}, {8'h00, ea});
				@(posedge clk_i);
				rd_data_i <= 16'($random(seed));
				access(1'b0, 1'b0, 8'h00, 4'h0, 16'h0000);
				er++;
				chk(16'(n_rd), 16'(er));
				chk(rdata_o, rd_data_i & m);
			end
		end
		summarize();
	end
	// Watchdog well beyond the expected run of about 1,500 cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		summarize();
	end
endmodule : sbd_tb_top
`default_nettype wire
